// *** core/ccmm_pkg.sv ***
package ccmm_pkg;

  // ************************************************************
  // address map
  // ************************************************************
  localparam logic [23:0] CCMM_IO_LOW_LAST = 24'h00_003f;
  localparam logic [23:0] CCMM_IO_EXT_FIRST = 24'h00_0040;
  localparam logic [23:0] CCMM_IO_LAST = 24'h00_0fff;
  localparam logic [23:0] CCMM_NVD_FIRST = 24'h00_1000;
  localparam logic [23:0] CCMM_NVD_LAST = 24'h00_1fff;
  localparam logic [23:0] CCMM_SRAM_FIRST = 24'h00_2000;
  localparam logic [23:0] CCMM_PC_RESET = 24'h00_0000;
  localparam logic [7:0] CCMM_SREG_RESET = 8'h00;
  localparam logic [4:0] CCMM_PTR_X = 5'h1a;
  localparam logic [4:0] CCMM_PTR_Y = 5'h1c;
  localparam logic [4:0] CCMM_PTR_Z = 5'h1e;
  localparam int CCMM_SREG_C = 0;
  localparam int CCMM_SREG_Z = 1;
  localparam int CCMM_SREG_N = 2;
  localparam int CCMM_SREG_V = 3;

  // ************************************************************
  // operations and regions
  // ************************************************************
  typedef enum logic [3:0] {
    CCMM_OP_NOP, CCMM_OP_ADD, CCMM_OP_SUB, CCMM_OP_AND, CCMM_OP_OR,
    CCMM_OP_XOR, CCMM_OP_MOV, CCMM_OP_INC, CCMM_OP_DEC, CCMM_OP_COM,
    CCMM_OP_LD, CCMM_OP_ST, CCMM_OP_IN, CCMM_OP_OUT, CCMM_OP_SPS,
    CCMM_OP_JMP
  } ccmm_op_t;

  typedef enum logic [2:0] {
    CCMM_RG_NONE, CCMM_RG_IO, CCMM_RG_NVD, CCMM_RG_SRAM
  } ccmm_region_t;

  // decoded instruction word: op, dest, source, immediate select
  typedef struct packed {
    ccmm_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic use_imm;
    logic [1:0] ptr;
    logic [4:0] spare;
    logic [7:0] imm;
  } ccmm_instr_t;

  // data bus request carrier
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wide;
    logic rd;
    logic wr;
  } ccmm_dreq_t;

  // program memory protection set
  typedef struct packed {
    logic app_wr_lock;
    logic app_rd_lock;
    logic tbl_wr_lock;
    logic tbl_rd_lock;
    logic boot_wr_lock;
    logic boot_rd_lock;
  } ccmm_lock_t;

endpackage : ccmm_pkg

// *** core/ccmm_decoder.sv ***
`timescale 1ns/1ps
module ccmm_decoder
  import ccmm_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic [23:0] sram_size,
  output ccmm_region_t region,
  output logic [23:0] offset
);

  // ************************************************************
  // data space region decode
  // ************************************************************
  // unclaimed space returns none so the core can zero it
  always_comb begin
    offset = addr;
    if (addr <= CCMM_IO_LAST) begin // [RULE9]
      region = CCMM_RG_IO;
    end else if (addr >= CCMM_NVD_FIRST && addr <= CCMM_NVD_LAST) begin
      region = CCMM_RG_NVD; // [RULE12]
      offset = addr - CCMM_NVD_FIRST;
    end else if (addr >= CCMM_SRAM_FIRST &&
                 addr - CCMM_SRAM_FIRST < sram_size) begin
      region = CCMM_RG_SRAM; // [RULE13]
      offset = addr - CCMM_SRAM_FIRST;
    end else begin
      region = CCMM_RG_NONE; // [RULE21]
    end
  end

endmodule : ccmm_decoder

// *** core/ccmm_core.sv ***
`timescale 1ns/1ps
// Overview of operation
// RULE1: separate program and data buses in parallel
// RULE2: single-stage overlapped fetch and execute pipeline
// RULE3: prefetch next word while executing current
// RULE4: thirty-two eight-bit registers, single-cycle access
// RULE5: two source operands, one-cycle completion
// RULE6: three sixteen-bit pointer pairs from six registers
// RULE7: register, immediate and single-register ALU operations
// RULE8: arithmetic updates the status flags
// RULE9: peripheral registers in bottom 4KB
// RULE10: low sixty-four I/O via short form
// RULE11: extended I/O only by data loads/stores
// RULE12: 0x1000-0x1FFF reserved for nonvolatile data
// RULE13: SRAM from 0x2000, all addressing modes
// RULE14: fetch only from program memory
// RULE15: self-program store only from boot section
// RULE16: application and boot sections own lock bits
// RULE17: table sub-section has separate lock bits
// RULE18: sixteen megabyte program and data spaces; data addresses only reach 0x0000-0xFFFF
// RULE19: multi-byte I/O accessed as coherent value
// RULE20: fetch starts at address zero after reset
// RULE21: unmapped reads zero, writes ignored
module ccmm_core
  import ccmm_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter logic [23:0] SRAM_SIZE = 24'h00_1000,
  parameter logic [23:0] BOOT_FIRST = 24'h00_4000,
  parameter logic [23:0] TBL_FIRST = 24'h00_3000
)
(
  input wire logic clk_sys,
  input wire logic reset,
  output logic [23:0] pm_addr,
  output logic pm_rd,
  input wire logic [31:0] pm_rdata,
  output logic [23:0] spm_addr,
  output logic [15:0] spm_wdata,
  output logic spm_wr,
  output logic spm_denied,
  input wire ccmm_lock_t locks,
  output logic [23:0] dm_addr,
  output logic [15:0] dm_wdata,
  output logic dm_wide,
  output logic dm_rd,
  output logic dm_wr,
  output ccmm_region_t dm_region,
  input wire logic [15:0] dm_rdata,
  output logic [7:0] sreg,
  output logic [31:0] retired
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ADDR_W != 24) begin : g_addr_w_check
    $error("ccmm_core: address width must be 24");
  end
  if (TBL_FIRST >= BOOT_FIRST) begin : g_section_check
    $error("ccmm_core: table section must sit below boot section");
  end

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] gpr_reg [32]; // [RULE4]
  logic [23:0] pc_reg;
  logic [23:0] pc_next;
  logic [23:0] exec_pc_reg;
  ccmm_instr_t ir_reg;
  logic ir_valid_reg;
  logic [7:0] sreg_reg;
  logic [7:0] sreg_next;
  logic load_pend_reg;
  logic load_wide_reg;
  logic [4:0] load_rd_reg;
  logic [31:0] retired_reg;

  ccmm_instr_t ins;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [8:0] alu_res;
  logic [7:0] alu_out;
  logic alu_we;
  logic [15:0] ptr_val;
  logic [23:0] d_addr;
  ccmm_region_t d_region;
  logic [23:0] d_offset;
  logic d_rd;
  logic d_wr;
  logic d_wide;
  logic spm_ok;

  assign ins = ir_reg;

  // ************************************************************
  // helpers
  // ************************************************************
  // pointer pair read: low register then the one above it
  function automatic logic [15:0] ccmm_pair(input logic [4:0] base,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    ccmm_pair = {hi, lo};
  endfunction : ccmm_pair

  function automatic logic ccmm_in_boot(input logic [23:0] a);
    ccmm_in_boot = (a >= BOOT_FIRST);
  endfunction : ccmm_in_boot

  function automatic logic ccmm_in_tbl(input logic [23:0] a);
    ccmm_in_tbl = (a >= TBL_FIRST) && (a < BOOT_FIRST);
  endfunction : ccmm_in_tbl

  // ************************************************************
  // operand read and ALU
  // ************************************************************
  // both sources read in the same cycle, the second from the file or the immediate
  always_comb begin
    op_a = gpr_reg[ins.rd]; // [RULE5]
    op_b = ins.use_imm ? ins.imm : gpr_reg[ins.rr]; // [RULE7]
    alu_res = 9'h000;
    alu_we = 1'b0;
    case (ins.op)
      CCMM_OP_ADD: begin
        alu_res = {1'b0, op_a} + {1'b0, op_b};
        alu_we = 1'b1;
      end
      CCMM_OP_SUB: begin
        alu_res = {1'b0, op_a} - {1'b0, op_b};
        alu_we = 1'b1;
      end
      CCMM_OP_AND: begin
        alu_res = {1'b0, op_a & op_b};
        alu_we = 1'b1;
      end
      CCMM_OP_OR: begin
        alu_res = {1'b0, op_a | op_b};
        alu_we = 1'b1;
      end
      CCMM_OP_XOR: begin
        alu_res = {1'b0, op_a ^ op_b};
        alu_we = 1'b1;
      end
      CCMM_OP_MOV: begin
        alu_res = {1'b0, op_b};
        alu_we = 1'b1;
      end
      // single-register forms
      CCMM_OP_INC: begin
        alu_res = {1'b0, op_a} + 9'h001;
        alu_we = 1'b1;
      end
      CCMM_OP_DEC: begin
        alu_res = {1'b0, op_a} - 9'h001;
        alu_we = 1'b1;
      end
      CCMM_OP_COM: begin
        alu_res = {1'b1, ~op_a};
        alu_we = 1'b1;
      end
      default: begin
        alu_res = 9'h000;
      end
    endcase
    alu_out = alu_res[7:0];
  end

  // status flags from the result of this operation
  always_comb begin
    sreg_next = sreg_reg;
    if (ir_valid_reg && alu_we && ins.op != CCMM_OP_MOV) begin // [RULE8]
      sreg_next[CCMM_SREG_Z] = (alu_out == 8'h00);
      sreg_next[CCMM_SREG_N] = alu_out[7];
      if (ins.op == CCMM_OP_ADD || ins.op == CCMM_OP_SUB ||
          ins.op == CCMM_OP_COM) begin
        sreg_next[CCMM_SREG_C] = alu_res[8];
      end
      if (ins.op == CCMM_OP_ADD) begin
        sreg_next[CCMM_SREG_V] = (op_a[7] == op_b[7]) &&
                                 (alu_out[7] != op_a[7]);
      end else if (ins.op == CCMM_OP_SUB) begin
        sreg_next[CCMM_SREG_V] = (op_a[7] != op_b[7]) &&
                                 (alu_out[7] != op_a[7]);
      end else begin
        sreg_next[CCMM_SREG_V] = 1'b0;
      end
    end
  end

  // ************************************************************
  // data address generation
  // ************************************************************
  // pointers X, Y, Z are the top six registers in pairs
  always_comb begin
    case (ins.ptr)
      2'd0: ptr_val = ccmm_pair(CCMM_PTR_X, gpr_reg[CCMM_PTR_X],
                                gpr_reg[CCMM_PTR_X + 5'd1]); // [RULE6]
      2'd1: ptr_val = ccmm_pair(CCMM_PTR_Y, gpr_reg[CCMM_PTR_Y],
                                gpr_reg[CCMM_PTR_Y + 5'd1]);
      default: ptr_val = ccmm_pair(CCMM_PTR_Z, gpr_reg[CCMM_PTR_Z],
                                   gpr_reg[CCMM_PTR_Z + 5'd1]);
    endcase
    d_rd = 1'b0;
    d_wr = 1'b0;
    d_wide = 1'b0;
    d_addr = {8'h00, ptr_val}; // [RULE18]
    if (ir_valid_reg) begin
      case (ins.op)
        // short form only reaches the lowest 64 locations
        CCMM_OP_IN: begin
          d_addr = {18'h0_0000, ins.imm[5:0]}; // [RULE10]
          d_rd = 1'b1;
        end
        CCMM_OP_OUT: begin
          d_addr = {18'h0_0000, ins.imm[5:0]}; // [RULE10]
          d_wr = 1'b1;
        end
        // long forms reach extended I/O, nonvolatile data and SRAM
        CCMM_OP_LD: begin
          d_rd = 1'b1; // [RULE11] [RULE13]
          d_wide = ins.spare[0];
        end
        CCMM_OP_ST: begin
          d_wr = 1'b1; // [RULE11] [RULE13]
          d_wide = ins.spare[0];
        end
        default: begin
          d_rd = 1'b0;
        end
      endcase
    end
  end

  ccmm_decoder u_dec (
    .addr(d_addr),
    .sram_size(SRAM_SIZE),
    .region(d_region),
    .offset(d_offset)
  );

  // ************************************************************
  // self-program store permission
  // ************************************************************
  // store must sit in boot; target section must not be write locked
  always_comb begin
    spm_ok = ccmm_in_boot(exec_pc_reg); // [RULE15]
    if (ccmm_in_boot({8'h00, ptr_val})) begin
      spm_ok = spm_ok && !locks.boot_wr_lock; // [RULE16]
    end else if (ccmm_in_tbl({8'h00, ptr_val})) begin
      spm_ok = spm_ok && !locks.tbl_wr_lock; // [RULE17]
    end else begin
      spm_ok = spm_ok && !locks.app_wr_lock; // [RULE16]
    end
  end

  // ************************************************************
  // fetch
  // ************************************************************
  // no load interlock: the word after a load still sees the old value
  always_comb begin
    pc_next = pc_reg + 24'h00_0001; // [RULE3]
    // first cycle out of reset: hold zero so word zero is fetched
    if (!pm_rd) begin
      pc_next = pc_reg; // [RULE20]
    end
    if (ir_valid_reg && ins.op == CCMM_OP_JMP) begin
      pc_next = {ins.spare, ins.rr, ins.rd, ins.imm, 1'b0};
    end
  end

  // program bus only; no path from data memory into the word
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc_reg <= CCMM_PC_RESET; // [RULE20]
      pm_addr <= CCMM_PC_RESET;
      pm_rd <= 1'b0;
      exec_pc_reg <= CCMM_PC_RESET;
      ir_reg <= '0;
      ir_valid_reg <= 1'b0;
    end else begin
      pm_rd <= 1'b1; // [RULE1] [RULE14]
      if (ir_valid_reg && ins.op == CCMM_OP_JMP) begin
        // taken jump squashes the word fetched behind it
        pc_reg <= pc_next;
        pm_addr <= pc_next;
        ir_valid_reg <= 1'b0;
      end else begin
        pc_reg <= pc_next; // [RULE2]
        pm_addr <= pc_next;
        ir_reg <= ccmm_instr_t'(pm_rdata[31:2]); // low two bits unused
        exec_pc_reg <= pm_addr;
        ir_valid_reg <= pm_rd;
      end
    end
  end

  // ************************************************************
  // data bus
  // ************************************************************
  // wide accesses go out as one request, not two byte moves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dm_addr <= 24'h00_0000;
      dm_wdata <= 16'h0000;
      dm_wide <= 1'b0;
      dm_rd <= 1'b0;
      dm_wr <= 1'b0;
      dm_region <= CCMM_RG_NONE;
    end else begin
      dm_addr <= d_offset;
      dm_region <= d_region;
      dm_wide <= d_wide && d_region == CCMM_RG_IO; // [RULE19]
      dm_wdata <= {gpr_reg[ins.rd + 5'd1], gpr_reg[ins.rd]}; // [RULE19]
      dm_rd <= d_rd && d_region != CCMM_RG_NONE; // [RULE21]
      dm_wr <= d_wr && d_region != CCMM_RG_NONE; // [RULE21]
    end
  end

  // load result returns next cycle; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      load_pend_reg <= 1'b0;
      load_wide_reg <= 1'b0;
      load_rd_reg <= 5'd0;
    end else begin
      load_pend_reg <= d_rd;
      load_wide_reg <= d_wide;
      load_rd_reg <= ins.rd;
    end
  end

  // ************************************************************
  // register file write-back
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        gpr_reg[i] <= 8'h00;
      end
    end else begin
      if (ir_valid_reg && alu_we) begin
        gpr_reg[ins.rd] <= alu_out; // [RULE4] [RULE5]
      end
      if (load_pend_reg) begin
        // dm_rd already gated; a none region reads as zero
        gpr_reg[load_rd_reg] <= (dm_region == CCMM_RG_NONE) ?
                                8'h00 : dm_rdata[7:0]; // [RULE21]
        if (load_wide_reg) begin
          gpr_reg[load_rd_reg + 5'd1] <= (dm_region == CCMM_RG_NONE) ?
                                         8'h00 : dm_rdata[15:8];
        end
      end
    end
  end

  // ************************************************************
  // status, self-program port and counters
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sreg_reg <= CCMM_SREG_RESET;
      sreg <= CCMM_SREG_RESET;
      spm_addr <= 24'h00_0000;
      spm_wdata <= 16'h0000;
      spm_wr <= 1'b0;
      spm_denied <= 1'b0;
      retired_reg <= 32'h0000_0000;
      retired <= 32'h0000_0000;
    end else begin
      sreg_reg <= sreg_next;
      sreg <= sreg_next;
      spm_addr <= {8'h00, ptr_val};
      spm_wdata <= {gpr_reg[5'd1], gpr_reg[5'd0]};
      spm_wr <= ir_valid_reg && ins.op == CCMM_OP_SPS && spm_ok; // [RULE15]
      spm_denied <= ir_valid_reg && ins.op == CCMM_OP_SPS && !spm_ok;
      // one retire per cycle shows the overlap at work
      if (ir_valid_reg) begin
        retired_reg <= retired_reg + 32'h0000_0001; // [RULE3]
      end
      retired <= ir_valid_reg ? retired_reg + 32'h0000_0001 : retired_reg;
    end
  end

endmodule : ccmm_core

// *** dv/ccmm_core_props.sv ***
`timescale 1ns/1ps
module ccmm_core_props
  import ccmm_pkg::*;
#(
  parameter logic [23:0] SRAM_SIZE = 24'h00_1000,
  parameter logic [23:0] BOOT_FIRST = 24'h00_4000,
  parameter logic [23:0] TBL_FIRST = 24'h00_3000
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [23:0] pm_addr,
  input wire logic pm_rd,
  input wire logic [23:0] spm_addr,
  input wire logic spm_wr,
  input wire logic spm_denied,
  input wire ccmm_lock_t locks,
  input wire logic [23:0] dm_addr,
  input wire logic dm_wide,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire ccmm_region_t dm_region,
  input wire logic [7:0] sreg,
  input wire logic [31:0] retired
);
  // ****************
  // core port checks
  // ****************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic strobe;
  // any data strobe
  assign strobe = dm_rd || dm_wr;

  sequence s_fetch_run;
    pm_rd [*4];
  endsequence

  reset_state_a: assert property (disable iff (1'b0)
    reset |=> pm_addr == CCMM_PC_RESET && sreg == CCMM_SREG_RESET && !strobe)
    else $error("core state not cleared by reset");
  fetch_start_a: assert property ($fell(reset) |=>
    (pm_addr == CCMM_PC_RESET) ##0 s_fetch_run)
    else $error("fetch did not start at zero");
  retire_step_a: assert property (!$past(reset) |->
    retired == $past(retired) || retired == $past(retired) + 32'h0000_0001)
    else $error("retire count jumped");
  unmapped_quiet_a: assert property (strobe |->
    dm_region != CCMM_RG_NONE) else $error("strobe on unmapped address");
  io_range_a: assert property (strobe && dm_region == CCMM_RG_IO |->
    dm_addr <= CCMM_IO_LAST) else $error("io access above io space");
  nvd_range_a: assert property (strobe &&
    dm_region == CCMM_RG_NVD |-> dm_addr <= CCMM_NVD_LAST - CCMM_NVD_FIRST)
    else $error("nonvolatile offset out of range");
  sram_range_a: assert property (strobe &&
    dm_region == CCMM_RG_SRAM |-> dm_addr < SRAM_SIZE)
    else $error("sram offset out of range");
  spm_excl_a: assert property (spm_wr |-> !spm_denied)
    else $error("store both done and refused");
  app_lock_a: assert property (spm_wr && spm_addr < TBL_FIRST |->
    !locks.app_wr_lock) else $error("locked application written");
  tbl_lock_a: assert property (spm_wr && spm_addr >= TBL_FIRST &&
    spm_addr < BOOT_FIRST |-> !locks.tbl_wr_lock)
    else $error("locked table written");
  wide_io_a: assert property (dm_wide |->
    strobe && dm_region == CCMM_RG_IO)
    else $error("wide access outside io space");
endmodule : ccmm_core_props

bind ccmm_core ccmm_core_props #(.SRAM_SIZE(SRAM_SIZE),
  .BOOT_FIRST(BOOT_FIRST), .TBL_FIRST(TBL_FIRST)) u_props (
  .clk_sys(clk_sys), .reset(reset), .pm_addr(pm_addr), .pm_rd(pm_rd),
  .spm_addr(spm_addr), .spm_wr(spm_wr), .spm_denied(spm_denied),
  .locks(locks), .dm_addr(dm_addr), .dm_wide(dm_wide), .dm_rd(dm_rd),
  .dm_wr(dm_wr), .dm_region(dm_region), .sreg(sreg), .retired(retired));

// *** dv/ccmm_mem_model.sv ***
`timescale 1ns/1ps
module ccmm_mem_model
  import ccmm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [23:0] pm_addr,
  input wire logic pm_rd,
  output logic [31:0] pm_rdata,
  input wire logic [23:0] dm_addr,
  input wire logic [15:0] dm_wdata,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire ccmm_region_t dm_region,
  output logic [15:0] dm_rdata
);
  logic [31:0] rom [0:255];
  logic [15:0] ram [0:255];
  logic [7:0] idx;
  // each region keeps its own cells
  assign idx = {dm_region[1:0], dm_addr[5:0]};
  // program store answers within the cycle the address stands
  // inverted word while idle so a stray capture shows
  assign pm_rdata = pm_rd ? rom[pm_addr[7:0]] : ~rom[pm_addr[7:0]];
  // data store write side
  always @(posedge clk_sys) begin
    if (dm_wr) begin
      ram[idx] <= dm_wdata;
    end
  end
  // read answer stands with the strobe, taken at the edge that ends it
  assign dm_rdata = dm_rd ? ram[idx] : ~ram[idx] ^ 16'h5a5a;
endmodule : ccmm_mem_model

// *** dv/ccmm_core_test.sv ***
`timescale 1ns/1ps
module ccmm_core_test;
  import ccmm_pkg::*;
  logic clk_sys, reset, pm_rd, spm_wr, spm_denied, dm_wide, dm_rd, dm_wr;
  logic [23:0] pm_addr, spm_addr, dm_addr;
  logic [31:0] pm_rdata, retired;
  logic [15:0] spm_wdata, dm_wdata, dm_rdata, spw;
  logic [7:0] sreg;
  ccmm_lock_t locks;
  ccmm_region_t dm_region;
  logic [42:0] evq [$];
  int fails, checks_done, nwr, nden, nwide, pc;
  // op, imm, a, b, flags, check flags
  localparam logic [31:0] ALU_TAB [12] = '{32'h1080_80b1, 32'h107f_01c1,
    32'h2001_0251, 32'h2180_0181, 32'h1196_3c00, 32'h3096_3c01,
    32'h4096_3c00, 32'h5096_3c00, 32'h6096_3c00, 32'h7096_3c00,
    32'h8096_3c00, 32'h9096_3c00};

  // short boot and table limits keep programs small
  ccmm_core #(.BOOT_FIRST(24'h00_0010), .TBL_FIRST(24'h00_0008)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata), .spm_addr(spm_addr), .spm_wdata(spm_wdata),
    .spm_wr(spm_wr), .spm_denied(spm_denied), .locks(locks),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_wide(dm_wide),
    .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_region(dm_region),
    .dm_rdata(dm_rdata), .sreg(sreg), .retired(retired));
  ccmm_mem_model u_mem (.clk_sys(clk_sys), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_region(dm_region), .dm_rdata(dm_rdata));

  // ****************
  // clock and monitor
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // log data writes and store pulses
  always @(posedge clk_sys) begin
    if (!reset) begin
      if (dm_wr === 1'b1) evq.push_back({dm_region, dm_addr, dm_wdata});
      nwr += (spm_wr === 1'b1);
      nden += (spm_denied === 1'b1);
      nwide += (dm_wide === 1'b1);
      if (spm_wr === 1'b1) spw = spm_wdata;
    end
  end
  // a hung run still ends in the report
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end

  // ****************
  // helpers
  // ****************
  task automatic cmp(string what, logic [42:0] e, logic [42:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic results();
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  function automatic logic [31:0] w(logic [3:0] op, logic [4:0] rd,
      logic [4:0] rr, logic ui, logic [1:0] ptr, logic [7:0] imm);
    return {op, rd, rr, ui, ptr, 5'h00, imm, 2'h0};
  endfunction : w
  function automatic logic [7:0] alu(logic [3:0] op, logic [7:0] a, b);
    case (op)
      4'h1: return a + b;
      4'h2: return a - b;
      4'h3: return a & b;
      4'h4: return a | b;
      4'h5: return a ^ b;
      4'h6: return b;
      4'h7: return a + 8'h01;
      4'h8: return a - 8'h01;
      default: return ~a;
    endcase
  endfunction : alu
  function automatic logic [26:0] dec(logic [23:0] a);
    if (a <= 24'h00_0fff) return {CCMM_RG_IO, a};
    if (a <= 24'h00_1fff) return {CCMM_RG_NVD, a - 24'h00_1000};
    if (a <= 24'h00_2fff) return {CCMM_RG_SRAM, a - 24'h00_2000};
    return {CCMM_RG_NONE, a};
  endfunction : dec
  task automatic put(logic [31:0] x);
    u_mem.rom[pc] = x;
    pc++;
  endtask : put
  task automatic mov(logic [4:0] rd, logic [7:0] v);
    put(w(4'h6, rd, 5'h00, 1'b1, 2'h0, v));
  endtask : mov
  task automatic blank();
    pc = 0;
    for (int i = 0; i < 256; i++) u_mem.rom[i] = 32'h0000_0000;
  endtask : blank
  // reset held five cycles, logs cleared
  task automatic restart(ccmm_lock_t lk);
    @(posedge clk_sys);
    #1 reset = 1'b1;
    locks = lk;
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    evq.delete();
    nwr = 0;
    nden = 0;
    nwide = 0;
    spw = 16'h0000;
  endtask : restart

  // ****************
  // scenarios
  // ****************
  task automatic t_fetch();
    logic [31:0] r0;
    blank();
    pc = 20;
    put(w(4'hf, 5'h00, 5'h00, 1'b0, 2'h0, 8'h20)); // jump to word 0x40
    restart('0);
    @(posedge clk_sys);
    #1 cmp("fetch start", 43'h100_0000, {pm_rd, pm_addr});
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_sys);
      #1 cmp("fetch addr", k, pm_addr);
    end
    r0 = retired;
    repeat (10) @(posedge clk_sys);
    #1 cmp("retired", r0 + 32'h0000_000a, retired);
    // jump at word 20 runs at edge 22 after release; its shadow is dropped
    repeat (10) @(posedge clk_sys);
    #1 cmp("jump target", 24'h00_0041, pm_addr);
  endtask : t_fetch
  task automatic t_alu();
    logic [31:0] e;
    for (int i = 0; i < 12; i++) begin
      e = ALU_TAB[i];
      blank();
      mov(5'h1c, 8'h10);
      mov(5'h1d, 8'h20);
      mov(5'h04, e[23:16]);
      mov(5'h05, e[15:8]);
      put(w(e[31:28], 5'h04, 5'h05, e[24], 2'h0, e[15:8]));
      pc++;
      put(w(4'hb, 5'h04, 5'h00, 1'b0, 2'h1, 8'h00));
      restart('0);
      repeat (20) @(posedge clk_sys);
      #1 cmp("alu store", {CCMM_RG_SRAM, 24'h00_0010, e[15:8],
        alu(e[31:28], e[23:16], e[15:8])}, evq.size() ? evq[0] : 43'h0);
      if (e[0]) cmp("flags", e[7:4], sreg[3:0]);
    end
  endtask : t_alu
  task automatic t_decode();
    logic [23:0] adr [8] = '{24'h00_003f, 24'h00_0040, 24'h00_0fff,
      24'h00_1000, 24'h00_1fff, 24'h00_2000, 24'h00_2fff, 24'h00_3000};
    logic [42:0] ex [$];
    blank();
    mov(5'h00, 8'ha5);
    mov(5'h01, 8'ha5);
    mov(5'h07, 8'ha5);
    mov(5'h08, 8'hff);
    mov(5'h09, 8'h00);
    mov(5'h0b, 8'ha5);
    foreach (adr[i]) begin
      mov(5'h1a, adr[i][7:0]);
      mov(5'h1b, adr[i][15:8]);
      // wide request at 0x3f (i/o) and at 0x2000 (sram, not widened)
      put(w(4'hb, 5'h00, 5'h00, 1'b0, 2'h0, 8'h00) |
        (i % 5 ? 32'h0000_0000 : 32'h0000_0400));
      if (dec(adr[i]) >> 24 != CCMM_RG_NONE) ex.push_back({dec(adr[i]),
        16'ha5a5});
    end
    put(w(4'ha, 5'h08, 5'h00, 1'b0, 2'h0, 8'h00));
    put(w(4'hd, 5'h00, 5'h00, 1'b0, 2'h0, 8'h21));
    put(w(4'hc, 5'h0a, 5'h00, 1'b0, 2'h0, 8'h21));
    mov(5'h1a, 8'h00);
    mov(5'h1b, 8'h20);
    put(w(4'ha, 5'h06, 5'h00, 1'b0, 2'h0, 8'h00));
    pc += 2;
    for (int i = 6; i < 11; i += 2) put(w(4'hb, i, 5'h00, 1'b0, 2'h0, 8'h00));
    ex.push_back({CCMM_RG_IO, 24'h00_0021, 16'ha5a5});
    ex.push_back({CCMM_RG_SRAM, 24'h00_0000, 16'ha5a5});
    ex.push_back({CCMM_RG_SRAM, 24'h00_0000, 16'h0000});
    ex.push_back({CCMM_RG_SRAM, 24'h00_0000, 16'ha5a5});
    restart('0);
    repeat (80) @(posedge clk_sys);
    #1 cmp("write count", ex.size(), evq.size());
    foreach (ex[i]) begin
      cmp("data write", ex[i], i < evq.size() ? evq[i] : 43'h0);
    end
    cmp("wide strobes", 1, nwide);
  endtask : t_decode
  task automatic t_spm();
    logic [23:0] cs [4] = '{24'h00_0011, 24'h20_0002, 24'h08_0802,
      24'h03_0811};
    foreach (cs[i]) begin
      blank();
      mov(5'h1e, cs[i][15:8]);
      mov(5'h1f, 8'h00);
      mov(5'h00, 8'h3c);
      pc = 3;
      put(w(4'he, 5'h00, 5'h00, 1'b0, 2'h2, 8'h00));
      pc = 16;
      put(w(4'he, 5'h00, 5'h00, 1'b0, 2'h2, 8'h00));
      restart(cs[i][21:16]);
      repeat (40) @(posedge clk_sys);
      #1 cmp("store done", cs[i][7:4], nwr);
      cmp("store refused", cs[i][3:0], nden);
      cmp("store data", cs[i][4] ? 16'h003c : 16'h0000, spw);
    end
  endtask : t_spm

  initial begin
    reset = 1'b1;
    locks = '0;
    fails = 0;
    checks_done = 0;
    t_fetch();
    t_alu();
    t_decode();
    t_spm();
    results();
  end
endmodule : ccmm_core_test
